//--- tb/host_model.sv
// Host-side model: wake pin, direct inputs and serial word stream
`timescale 1ns/1ps
module host_model (
    input  wire logic       mclk_in,
    input  wire logic       wake_req_in,
    input  wire logic [1:0] direct_req_in,
    input  wire logic       send_in,
    input  wire logic       bit_in,
    output logic            wake_reset_pin_out,
    output logic [1:0]      direct_out,
    output logic            word_valid_out,
    output logic            toggle_bit_out
);
    // Known levels before the first edge
    initial begin
        wake_reset_pin_out = 1'b0;
        direct_out         = 2'h0;
        word_valid_out     = 1'b0;
        toggle_bit_out     = 1'b0;
    end

    // Wake pin or input activity wakes; the bench holds the pin high for slow input rates
    always @(posedge mclk_in) begin
        wake_reset_pin_out <= wake_req_in;
        direct_out         <= direct_req_in;
    end

    // One word per request; between words the bit line flips, so a stale bit never passes
    always @(posedge mclk_in) begin
        word_valid_out <= send_in;
        toggle_bit_out <= send_in ? bit_in : ~toggle_bit_out;
    end
endmodule : host_model

//--- tb/test_switch_mode_supervisor.sv
// Self-checking bench for the operating-mode supervisor
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module test_switch_mode_supervisor;
    // Short counts keep the run small
    localparam int WDOG  = 60;
    localparam int INACT = 50;
    int                                n_mismatch  = 0;
    int                                comparisons = 0;
    logic                              mclk_in     = 1'b0;
    logic                              reset_n_in  = 1'b0;
    logic                              wake_req    = 1'b0;
    logic [1:0]                        dir_req     = 2'h0;
    logic                              send        = 1'b0;
    logic                              send_bit    = 1'b0;
    logic                              ext_clock   = 1'b0;
    logic [7:0]                        global_config_reg         = 8'h10;
    supervisor_pkg::chan_cfg_t   [1:0] cfg         = '0;
    supervisor_pkg::chan_fault_t [1:0] faults      = '0;
    logic                              supply_ok   = 1'b1;
    logic                              fail_en     = 1'b0;
    logic                              uv          = 1'b0;
    logic                              ov          = 1'b0;
    logic                              ov_en       = 1'b0;
    logic                              wake_pin;
    logic [1:0]                        direct;
    logic                              word_valid;
    logic                              toggle_bit;
    logic [1:0]                        mode;
    logic                              nm_flag;
    logic                              fs_n;
    logic                              regs_clear;
    logic                              ready;
    logic [1:0]                        chan_on;
    logic [1:0]                        chan_fault;

    always #12.5 mclk_in = ~mclk_in;
    // External PWM clock, deliberately off the system clock grid
    always #201 ext_clock = ~ext_clock;

    host_model host (.mclk_in(mclk_in), .wake_req_in(wake_req), .direct_req_in(dir_req), .send_in(send),
        .bit_in(send_bit), .wake_reset_pin_out(wake_pin), .direct_out(direct), .word_valid_out(word_valid),
        .toggle_bit_out(toggle_bit));

    switch_mode_supervisor #(.WDOG_CYCLES(WDOG), .INACT_CYCLES(INACT)) uut (.mclk_in(mclk_in),
        .reset_n_in(reset_n_in), .wake_reset_pin_in(wake_pin), .direct_in(direct), .ext_clock_in(ext_clock),
        .word_valid_in(word_valid), .watchdog_toggle_bit_in(toggle_bit), .global_config_reg_in(global_config_reg),
        .chan_cfg_in(cfg), .prescale_in(8'h03), .logic_supply_ok_in(supply_ok), .supply_fail_enable_in(fail_en),
        .chan_fault_in(faults), .undervoltage_fault_in(uv), .overvoltage_fault_in(ov),
        .overvoltage_fault_enable_in(ov_en), .mode_out(mode), .normal_mode_flag_out(nm_flag),
        .failsafe_out_n_out(fs_n), .regs_clear_out(regs_clear), .ready_out(ready), .chan_on_out(chan_on),
        .chan_fault_out(chan_fault));

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
    endtask : cyc

    // Polls on falling edges so registered outputs have settled
    task automatic wait_mode(input logic [1:0] m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++) begin
            @(negedge mclk_in);
        end
    endtask : wait_mode

    task automatic send_word(input logic b);
        @(posedge mclk_in);
        send     <= 1'b1;
        send_bit <= b;
        @(posedge mclk_in);
        send <= 1'b0;
    endtask : send_word

    task automatic set_cfg(input logic on, input logic pwm, input logic ovr, input logic sel, input logic [7:0] d);
        @(posedge mclk_in);
        for (int c = 0; c < 2; c++) begin
            cfg[c] <= '{on, pwm, ovr, sel, d};
        end
    endtask : set_cfg

    task automatic do_reset();
        @(posedge mclk_in);
        reset_n_in <= 1'b0;
        wake_req   <= 1'b0;
        dir_req    <= 2'h0;
        cyc(4);
        @(negedge mclk_in);
        `CHECK(mode, 2'h0)
        `CHECK(nm_flag, 1'b0)
        `CHECK(fs_n, 1'b1)
        `CHECK(chan_on, 2'h0)
        @(posedge mclk_in);
        reset_n_in <= 1'b1;
    endtask : do_reset

    task automatic t_wake();
        int pulses = 0;
        @(posedge mclk_in);
        wake_req <= 1'b1;
        repeat (12) begin
            @(negedge mclk_in);
            pulses += int'(regs_clear === 1'b1);
        end
        `CHECK(pulses, 1)
        `CHECK(mode, 2'h1)
        `CHECK(nm_flag, 1'b1)
        `CHECK(ready, 1'b0)
        cyc(2000);
        @(negedge mclk_in);
        `CHECK(ready, 1'b1)
    endtask : t_wake

    task automatic t_target();
        int ones;
        set_cfg(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        cyc(4);
        @(negedge mclk_in);
        `CHECK(chan_on, 2'h3)
        set_cfg(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        dir_req <= 2'h1;
        cyc(8);
        @(negedge mclk_in);
        `CHECK(chan_on, 2'h1)
        set_cfg(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        cyc(4);
        @(negedge mclk_in);
        `CHECK(chan_on, 2'h0)
        dir_req <= 2'h0;
        // Duty 0x40 external, 0x80 internal: on-share tracks the low byte
        for (int k = 0; k < 3; k++) begin
            set_cfg(1'b1, 1'b1, 1'b0, k[0], (k == 0) ? 8'h00 : {k[1:0], 6'h00});
            ones = 0;
            repeat (4096) begin
                @(negedge mclk_in);
                ones += int'(chan_on[0] === 1'b1);
            end
            `CHECK((ones >= k * 1024 - 400 + (k == 0) * 400) && (ones <= k * 1024 + 400), 1'b1)
        end
    endtask : t_target

    task automatic t_fault();
        set_cfg(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        ov <= 1'b1;
        cyc(8);
        @(negedge mclk_in);
        `CHECK(mode, 2'h1)
        for (int k = 0; k < 5; k++) begin
            @(posedge mclk_in);
            ov_en                          <= (k == 0);
            faults[0].overcurrent_fault    <= (k == 1);
            faults[1].overtemp_fault       <= (k == 2);
            uv                             <= (k == 3);
            faults[0].severe_short_fault   <= (k == 4);
            wait_mode(2'h3, 10);
            `CHECK(mode, 2'h3)
            `CHECK(chan_on, 2'h0)
            `CHECK(chan_fault, (k == 2) ? 2'h2 : ((k == 1 || k == 4) ? 2'h1 : 2'h0))
            @(posedge mclk_in);
            ov_en  <= 1'b0;
            faults <= '0;
            uv     <= 1'b0;
            wait_mode(2'h1, 10);
            `CHECK(mode, 2'h1)
        end
        @(posedge mclk_in);
        ov <= 1'b0;
    endtask : t_fault

    task automatic t_watchdog();
        @(posedge mclk_in);
        global_config_reg <= 8'h00;
        for (int i = 0; i < 6; i++) begin
            send_word(~i[0]);
            cyc(25);
        end
        `CHECK(mode, 2'h1)
        wait_mode(2'h2, WDOG + 30);
        `CHECK(mode, 2'h2)
        `CHECK(fs_n, 1'b0)
        @(posedge mclk_in);
        dir_req <= 2'h1;
        cyc(8);
        @(negedge mclk_in);
        `CHECK(chan_on, 2'h1)
        send_word(1'b1);
        cyc(10);
        send_word(1'b0);
        wait_mode(2'h1, 20);
        `CHECK(mode, 2'h1)
        @(posedge mclk_in);
        global_config_reg     <= 8'h10;
        dir_req <= 2'h0;
        cyc(WDOG + 30);
        `CHECK(mode, 2'h1)
    endtask : t_watchdog

    task automatic t_supply();
        @(posedge mclk_in);
        global_config_reg       <= 8'h00;
        supply_ok <= 1'b0;
        cyc(WDOG + 30);
        `CHECK(mode, 2'h1)
        global_config_reg       <= 8'h10;
        supply_ok <= 1'b1;
        cyc(10);
        fail_en <= 1'b1;
        cyc(10);
        supply_ok <= 1'b0;
        wait_mode(2'h2, 20);
        `CHECK(mode, 2'h2)
        @(posedge mclk_in);
        supply_ok <= 1'b1;
        fail_en   <= 1'b0;
    endtask : t_supply

    task automatic t_sleep();
        int pulses = 0;
        dir_req <= 2'h2;
        // Direct-input wake must also clear the serial registers once
        repeat (12) begin
            @(negedge mclk_in);
            pulses += int'(regs_clear === 1'b1);
        end
        `CHECK(pulses, 1)
        `CHECK(mode, 2'h1)
        cyc(4);
        @(negedge mclk_in);
        `CHECK(chan_on, 2'h2)
        @(posedge mclk_in);
        dir_req <= 2'h0;
        cyc(INACT - 15);
        `CHECK(mode, 2'h1)
        wait_mode(2'h0, 40);
        `CHECK(mode, 2'h0)
        `CHECK(chan_on, 2'h0)
    endtask : t_sleep

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Hang guard, well beyond the expected run
    initial begin
        cyc(40000);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        do_reset();
        t_wake();
        t_target();
        t_fault();
        t_watchdog();
        t_supply();
        do_reset();
        t_sleep();
        end_of_test();
    end
endmodule : test_switch_mode_supervisor

//--- verilog/supervisor_pkg.sv
// Shared constants and types for the operating-mode supervisor
package supervisor_pkg;
    localparam int          CLK_HZ         = 40_000_000;
    localparam int          WAKE_US        = 50;
    localparam int          WAKE_CYC       = (CLK_HZ / 1_000_000) * WAKE_US;
    localparam int          WDOG_MS        = 310;
    localparam int          WDOG_CYC       = (CLK_HZ / 1000) * WDOG_MS;
    localparam int          INACT_MS       = 250;
    localparam int          INACT_CYC      = (CLK_HZ / 1000) * INACT_MS;
    localparam int          CNT_W          = 24;
    localparam int          NUM_CH         = 2;
    localparam int          DUTY_W         = 8;
    localparam int          GCR_WDOG_DIS   = 4;
    localparam logic [7:0]  DUTY_RESET     = 8'h00;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_NORMAL,
        MODE_FAILSAFE,
        MODE_FAULT
    } mode_t;

    // Per-channel protection flags
    typedef struct packed {
        logic overcurrent_fault;
        logic overtemp_fault;
        logic severe_short_fault;
    } chan_fault_t;

    // Per-channel control settings from the serial registers
    typedef struct packed {
        logic                   on_bit;
        logic                   pwm_enable;
        logic                   dir_override;
        logic                   ext_clock_sel;
        logic [DUTY_W-1:0]      duty;
    } chan_cfg_t;
endpackage : supervisor_pkg

//--- verilog/switch_mode_supervisor.sv
// Operating-mode supervisor and channel target logic for a dual power switch
// Overview of operation
// - Exactly one of sleep, normal, fail-safe, fault; two channels independent.
// - Normal mode channel control: direct input, internal PWM or external clock.
// - Wake-up resets serial registers, enters normal; ready after 50 us.
// - Target on-state ORs override input, PWM-gated on bit, and plain on bit.
// - Duty value comes from low eight bits of pulse width register.
// - Direct input mode: channel follows its input pin.
// - Internal clock mode: internal prescaled PWM per channel.
// - External clock mode: PWM period taken from external clock.
// - Rising wake reset pin or direct input enters normal mode.
// - Input-active flag clears after 250 ms of no input activity.
// - Sleep when both input-active flags and wake reset pin are low.
// - Pin low in normal mode, or fail-safe: channels follow direct inputs only.
// - Mode decode from wake-up, fail-safe and fault terms.
// - Fault term ORs channel faults, undervoltage, enabled overvoltage.
// - Fail-safe on watchdog timeout or enabled logic supply loss.
// - Watchdog disable bit blocks timeout from entering fail-safe.
// - Watchdog runs with logic supply, disable clear, pin high.
// - Fault mode holds both channels off.
// - Normal mode flag is one in normal mode.
// - Status reports per-channel on/off and normal/fault state.
// - Watchdog samples first bit of every word; a change is activity.
`timescale 1ns/1ps
module switch_mode_supervisor #(
    parameter int WDOG_CYCLES  = supervisor_pkg::WDOG_CYC,
    parameter int INACT_CYCLES = supervisor_pkg::INACT_CYC
) (
    input  wire logic                                       mclk_in,
    input  wire logic                                       reset_n_in,
    input  wire logic                                       wake_reset_pin_in,
    input  wire logic [supervisor_pkg::NUM_CH-1:0]          direct_in,
    input  wire logic                                       ext_clock_in,
    input  wire logic                                       word_valid_in,
    input  wire logic                                       watchdog_toggle_bit_in,
    input  wire logic [7:0]                                 global_config_reg_in,
    input  wire supervisor_pkg::chan_cfg_t [supervisor_pkg::NUM_CH-1:0] chan_cfg_in,
    input  wire logic [7:0]                                 prescale_in,
    input  wire logic                                       logic_supply_ok_in,
    input  wire logic                                       supply_fail_enable_in,
    input  wire supervisor_pkg::chan_fault_t [supervisor_pkg::NUM_CH-1:0] chan_fault_in,
    input  wire logic                                       undervoltage_fault_in,
    input  wire logic                                       overvoltage_fault_in,
    input  wire logic                                       overvoltage_fault_enable_in,
    output logic [1:0]                                      mode_out,
    output logic                                            normal_mode_flag_out,
    output logic                                            failsafe_out_n_out,
    output logic                                            regs_clear_out,
    output logic                                            ready_out,
    output logic [supervisor_pkg::NUM_CH-1:0]               chan_on_out,
    output logic [supervisor_pkg::NUM_CH-1:0]               chan_fault_out
);
    localparam int NCH = supervisor_pkg::NUM_CH;

    // Timeout counters are CNT_W wide; larger counts would wrap before expiry
    if (WDOG_CYCLES < 2 || WDOG_CYCLES >= (1 << supervisor_pkg::CNT_W) ||
        INACT_CYCLES < 2 || INACT_CYCLES >= (1 << supervisor_pkg::CNT_W)) begin : g_bad_count
        $error("timeout counts out of counter range");
    end

    // Two-stage synchronisers for asynchronous pins
    logic [NCH+1:0] sync1;
    logic [NCH+1:0] sync2;
    logic [NCH+1:0] sync_prev;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync1     <= '0;
            sync2     <= '0;
            sync_prev <= '0;
        end else begin
            sync1     <= {ext_clock_in, wake_reset_pin_in, direct_in};
            sync2     <= sync1;
            sync_prev <= sync2;
        end
    end

    logic [NCH-1:0] din;
    logic           pin_wake;
    logic           pin_rise;
    logic           ext_rise;
    assign din      = sync2[NCH-1:0];
    assign pin_wake = sync2[NCH];
    assign pin_rise = sync2[NCH] & ~sync_prev[NCH];
    assign ext_rise = sync2[NCH+1] & ~sync_prev[NCH+1];

    // Input-active flags with inactivity timeout, one per channel
    logic [NCH-1:0] in_active;
    logic [NCH-1:0] in_rise;
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_inact
            logic [supervisor_pkg::CNT_W-1:0] idle_cnt;
            logic                             act;
            assign act        = din[g] ^ sync_prev[g];
            assign in_rise[g] = din[g] & ~sync_prev[g];
            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    idle_cnt     <= '0;
                    in_active[g] <= 1'b0;
                end else if (act || din[g]) begin
                    // A held-high input counts as ongoing activity
                    idle_cnt     <= '0;
                    in_active[g] <= in_active[g] | in_rise[g];
                end else if (idle_cnt >= supervisor_pkg::CNT_W'(INACT_CYCLES)) begin
                    in_active[g] <= 1'b0;
                end else begin
                    idle_cnt <= idle_cnt + 1'b1;
                end
            end
        end
    endgenerate

    logic wake_term;
    assign wake_term = pin_wake | (|in_active);

    // Watchdog on the first bit of every serial word
    logic                             wd_bit_prev;
    logic [supervisor_pkg::CNT_W-1:0] wd_cnt;
    logic                             wd_timeout;
    logic                             wd_run;
    logic                             watchdog_disable_bit;
    assign watchdog_disable_bit = global_config_reg_in[supervisor_pkg::GCR_WDOG_DIS];
    assign wd_run = logic_supply_ok_in & ~watchdog_disable_bit & pin_wake;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wd_bit_prev <= 1'b0;
            wd_cnt      <= '0;
            wd_timeout  <= 1'b0;
        end else if (pin_rise || !wd_run) begin
            wd_cnt     <= '0; // Restarted on each wake edge
            wd_timeout <= 1'b0;
            if (word_valid_in)
                wd_bit_prev <= watchdog_toggle_bit_in;
        end else if (word_valid_in && watchdog_toggle_bit_in != wd_bit_prev) begin
            wd_bit_prev <= watchdog_toggle_bit_in;
            wd_cnt      <= '0;
            // Leaving fail-safe needs the toggle bit at one
            if (watchdog_toggle_bit_in)
                wd_timeout <= 1'b0;
        end else if (wd_cnt >= supervisor_pkg::CNT_W'(WDOG_CYCLES)) begin
            wd_timeout <= 1'b1;
        end else begin
            wd_cnt <= wd_cnt + 1'b1;
        end
    end

    // Logic supply loss is only a failure after it has been seen present
    logic supply_seen;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            supply_seen <= 1'b0;
        else if (logic_supply_ok_in)
            supply_seen <= 1'b1;
    end

    logic failsafe_term;
    logic fault_term;
    logic [NCH-1:0] ch_fault;
    always_comb begin
        for (int i = 0; i < NCH; i++)
            ch_fault[i] = |chan_fault_in[i];
        failsafe_term = (wd_timeout & ~watchdog_disable_bit) |
                        (supply_seen & ~logic_supply_ok_in & supply_fail_enable_in);
        fault_term    = (|ch_fault) | undervoltage_fault_in |
                        (overvoltage_fault_in & overvoltage_fault_enable_in);
    end

    // Mode decode
    supervisor_pkg::mode_t mode;
    supervisor_pkg::mode_t next_mode;
    always_comb begin
        if (!wake_term)
            next_mode = supervisor_pkg::MODE_SLEEP;
        else if (fault_term)
            next_mode = supervisor_pkg::MODE_FAULT;
        else if (failsafe_term)
            next_mode = supervisor_pkg::MODE_FAILSAFE;
        else
            next_mode = supervisor_pkg::MODE_NORMAL;
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            mode <= supervisor_pkg::MODE_SLEEP;
        else
            mode <= next_mode;
    end

    // Wake detection: any exit from sleep; the input-active flags lag the pin edge
    // by a cycle, so an edge qualifier here would miss direct-input wakes
    logic                             wake_event;
    logic [supervisor_pkg::CNT_W-1:0] settle_cnt;
    assign wake_event = (mode == supervisor_pkg::MODE_SLEEP)
                        && (next_mode != supervisor_pkg::MODE_SLEEP);
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            regs_clear_out <= 1'b0;
            settle_cnt     <= '0;
            ready_out      <= 1'b0;
        end else begin
            regs_clear_out <= wake_event;
            if (next_mode == supervisor_pkg::MODE_SLEEP) begin
                settle_cnt <= '0;
                ready_out  <= 1'b0;
            end else if (wake_event) begin
                settle_cnt <= '0;
                ready_out  <= 1'b0;
            end else if (settle_cnt >= supervisor_pkg::CNT_W'(supervisor_pkg::WAKE_CYC)) begin
                ready_out <= 1'b1;
            end else begin
                settle_cnt <= settle_cnt + 1'b1;
            end
        end
    end

    // Internal PWM period tick from prescaler; external clock edges otherwise
    logic [7:0] pre_cnt;
    logic       int_tick;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pre_cnt  <= '0;
            int_tick <= 1'b0;
        end else begin
            int_tick <= (pre_cnt >= prescale_in);
            pre_cnt  <= (pre_cnt >= prescale_in) ? 8'h00 : pre_cnt + 8'h01;
        end
    end

    // Per-channel duty waveform and target state
    logic [NCH-1:0] next_on;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            logic [supervisor_pkg::DUTY_W-1:0] phase;
            logic                              tick;
            logic                              duty_wave;
            assign tick      = chan_cfg_in[g].ext_clock_sel ? ext_rise : int_tick;
            assign duty_wave = phase < chan_cfg_in[g].duty;
            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in)
                    phase <= supervisor_pkg::DUTY_RESET;
                else if (tick)
                    phase <= phase + 1'b1;
            end
            // Decoded from the next mode so channel state and mode output move together
            always_comb begin
                unique case (next_mode)
                    supervisor_pkg::MODE_NORMAL:
                        next_on[g] = (din[g] & chan_cfg_in[g].dir_override) |
                                     (chan_cfg_in[g].on_bit & duty_wave & chan_cfg_in[g].pwm_enable) |
                                     (chan_cfg_in[g].on_bit & ~chan_cfg_in[g].pwm_enable);
                    supervisor_pkg::MODE_FAILSAFE:
                        next_on[g] = din[g];
                    supervisor_pkg::MODE_FAULT:
                        next_on[g] = 1'b0;
                    supervisor_pkg::MODE_SLEEP:
                        next_on[g] = 1'b0;
                endcase
                // Wake pin low: direct inputs alone steer the channel
                if (next_mode == supervisor_pkg::MODE_NORMAL && !pin_wake)
                    next_on[g] = din[g];
            end
        end
    endgenerate

    // Registered outputs
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_out             <= 2'h0;
            normal_mode_flag_out <= 1'b0;
            failsafe_out_n_out   <= 1'b1;
            chan_on_out          <= '0;
            chan_fault_out       <= '0;
        end else begin
            mode_out             <= next_mode;
            normal_mode_flag_out <= (next_mode == supervisor_pkg::MODE_NORMAL);
            failsafe_out_n_out   <= ~failsafe_term;
            chan_on_out          <= next_on;
            chan_fault_out       <= ch_fault;
        end
    end

    fault_off_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        mode == supervisor_pkg::MODE_FAULT |-> chan_on_out == '0)
        else $error("channel on during fault mode");
    normal_flag_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        normal_mode_flag_out == (mode == supervisor_pkg::MODE_NORMAL))
        else $error("normal flag mismatch");
    sleep_decode_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        !pin_wake && in_active == '0 |=> mode == supervisor_pkg::MODE_SLEEP)
        else $error("no sleep with wake term low");
    wd_disable_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        watchdog_disable_bit && logic_supply_ok_in |=> mode != supervisor_pkg::MODE_FAILSAFE)
        else $error("fail-safe despite watchdog disabled");
    fault_decode_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        wake_term && undervoltage_fault_in |=> mode == supervisor_pkg::MODE_FAULT)
        else $error("undervoltage not fault");
    wake_clear_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        wake_event |=> regs_clear_out && !ready_out)
        else $error("wake did not clear registers");
    failsafe_follow_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        mode == supervisor_pkg::MODE_FAILSAFE |-> chan_on_out == $past(din))
        else $error("fail-safe channel not following input");
    sync_delay_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        $rose(wake_reset_pin_in) ##1 wake_reset_pin_in |=> pin_wake)
        else $error("wake pin synchroniser latency");
endmodule : switch_mode_supervisor
